// file: src/cdp_core.sv
// cpu core datapath: prefetch, register file, alu, multiplier, divider, shifter
`timescale 1ns/100ps
`default_nettype none
`include "cdp_cfg.svh"

module cdp_core #(
  parameter logic [22:0] RESET_VECTOR = `CDP_RESET_VEC,
  parameter logic [22:0] IRQ_VECTOR = `CDP_IRQ_VEC
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // program memory bus
  output var cdp_pkg::cdp_pm_req_t pm_o,
  input wire logic [23:0] pm_data_i,
  // data memory bus
  output var cdp_pkg::cdp_dm_req_t dm_o,
  input wire logic [15:0] dm_rdata_i,
  // interrupt request
  input wire logic irq_i,
  output logic irq_ack_o
);

  // --------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------
  // variable-length opcode
  function automatic cdp_pkg::cdp_op_t decode_op(input logic [23:0] iw);
    cdp_pkg::cdp_op_t op;
    op = cdp_pkg::OP_NOP;
    if (iw[23]) begin
      op = iw[22] ? cdp_pkg::OP_CALL : cdp_pkg::OP_GOTO;
    end else begin
      unique case (iw[22:20])
        `CDP_OPC_ALU: op = cdp_pkg::OP_ALU;
        `CDP_OPC_MOVL: op = cdp_pkg::OP_MOVL;
        `CDP_OPC_LD: op = cdp_pkg::OP_LD;
        `CDP_OPC_ST: op = cdp_pkg::OP_ST;
        `CDP_OPC_MUL: op = cdp_pkg::OP_MUL;
        `CDP_OPC_SHIFT: op = cdp_pkg::OP_SHIFT;
        `CDP_OPC_EXT: begin
          if (iw[19:16] == `CDP_SUB_DIV) op = cdp_pkg::OP_DIV;
          else if (iw[19:16] == `CDP_SUB_REPEAT) op = cdp_pkg::OP_REPEAT;
          else if (iw[19:16] == `CDP_SUB_RET) op = cdp_pkg::OP_RET;
          else if (iw[19:16] == `CDP_SUB_CTRL) op = cdp_pkg::OP_CTRL;
          else op = cdp_pkg::OP_NOP;
        end
        default: op = cdp_pkg::OP_NOP;
      endcase
    end
    return op;
  endfunction

  cdp_pkg::cdp_state_t s_reg;
  cdp_pkg::cdp_state_t s_next;

  logic [23:0] ex_word;
  logic ex_valid;
  cdp_pkg::cdp_op_t ex_op;
  logic [3:0] f_rd;
  logic [3:0] f_ra;
  logic [3:0] f_rb;
  logic [15:0] opa;
  logic [15:0] opb;
  logic [15:0] opd;
  logic [15:0] ea;
  logic [22:0] fp_inc;
  logic [22:0] ret_addr;
  logic [15:0] sp_val;
  logic [15:0] sp_p2;
  logic [15:0] sp_m2;
  logic irq_take;

  // repeated word is replayed from a latch, so the bus prefetch holds its address
  assign ex_word = s_reg.rpt_started ? s_reg.rpt_ir : pm_data_i;
  assign ex_valid = s_reg.rpt_started | s_reg.iw_valid;
  assign ex_op = decode_op(ex_word);
  assign f_rd = ex_word[11:8];
  assign f_ra = ex_word[7:4];
  assign f_rb = ex_word[3:0];
  assign opa = s_reg.w[f_ra];
  assign opb = s_reg.w[f_rb];
  assign opd = s_reg.w[f_rd];
  assign ea = opa + opb;
  assign fp_inc = s_reg.fp + `CDP_FP_STEP;
  assign ret_addr = s_reg.fp - `CDP_FP_STEP;
  assign sp_val = s_reg.w[`CDP_SP_IDX];
  assign sp_p2 = sp_val + `CDP_SP_STEP;
  assign sp_m2 = sp_val - `CDP_SP_STEP;
  assign irq_take = irq_i & ~s_reg.in_isr & ex_valid & (s_reg.st == cdp_pkg::ST_RUN);

  // --------------------------------------------------------------------
  // alu, multiplier, shifter, divide step
  // --------------------------------------------------------------------
  logic [15:0] alu_res;
  always_comb begin
    unique case (ex_word[19:16])
      4'h0: alu_res = opa + opb;
      4'h1: alu_res = opa - opb;
      4'h2: alu_res = opa & opb;
      4'h3: alu_res = opa | opb;
      4'h4: alu_res = opa ^ opb;
      default: alu_res = opa;
    endcase
  end

  logic signed [16:0] mul_a;
  logic signed [16:0] mul_b;
  logic signed [33:0] mul_p;
  assign mul_a = {ex_word[19] & opa[15], opa};
  assign mul_b = {ex_word[18] & opb[15], opb};
  assign mul_p = mul_a * mul_b;

  logic [5:0] sh_amt;
  logic [5:0] sh_abs;
  logic [5:0] sh_mag;
  logic [31:0] sh_ext;
  logic [31:0] sh_right;
  logic [15:0] sh_res;
  assign sh_amt = ex_word[19:14];
  assign sh_abs = sh_amt[5] ? 6'(~sh_amt + 6'h01) : sh_amt;
  assign sh_mag = (sh_abs > `CDP_SHIFT_MAX) ? `CDP_SHIFT_MAX : sh_abs;
  assign sh_ext = {{16{ex_word[13] & opa[15]}}, opa};
  assign sh_right = sh_ext >> sh_mag;
  assign sh_res = sh_amt[5] ? (opa << sh_mag) : sh_right[15:0];

  // restoring step; 32/16 with high word >= divisor is undefined
  logic [16:0] div_part;
  logic div_ge;
  logic [16:0] div_diff;
  assign div_part = {s_reg.w[`CDP_REM_IDX], s_reg.w[`CDP_QUOT_IDX][15]};
  assign div_ge = div_part >= {1'b0, s_reg.divisor};
  assign div_diff = div_part - {1'b0, s_reg.divisor};

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.dm.rd = 1'b0;
    s_next.dm.wr = 1'b0;
    s_next.irq_ack = 1'b0;
    unique case (s_reg.st)
      cdp_pkg::ST_RUN: begin
        if (irq_take) begin
          s_next.dm.wr = 1'b1;
          s_next.dm.addr = sp_val[15:1];
          s_next.dm.wdata = ret_addr[15:0];
          s_next.w[`CDP_SP_IDX] = sp_p2;
          // repeat and divide state survive the handler
          s_next.link = {s_reg.rpt_active, s_reg.in_isr, 7'h00, ret_addr[22:16]};
          s_next.tgt = IRQ_VECTOR;
          s_next.in_isr = 1'b1;
          s_next.rpt_active = 1'b0;
          s_next.rpt_started = 1'b0;
          s_next.irq_ack = 1'b1;
          s_next.st = cdp_pkg::ST_PUSH_HI;
        end else if (!ex_valid) begin
          s_next.fp = fp_inc;
          s_next.pm.addr = fp_inc;
          s_next.iw_valid = 1'b1;
        end else begin
          // next word already on the bus
          s_next.fp = fp_inc;
          s_next.pm.addr = fp_inc;
          s_next.iw_valid = 1'b1;
          unique case (ex_op)
            cdp_pkg::OP_ALU: begin
              s_next.w[f_rd] = alu_res;
            end
            cdp_pkg::OP_MOVL: begin
              s_next.w[ex_word[19:16]] = ex_word[15:0];
            end
            cdp_pkg::OP_MUL: begin
              s_next.w[{f_rd[3:1], 1'b0}] = mul_p[15:0];
              s_next.w[{f_rd[3:1], 1'b1}] = mul_p[31:16];
            end
            cdp_pkg::OP_SHIFT: begin
              s_next.w[f_rd] = sh_res;
            end
            cdp_pkg::OP_ST: begin
              // write posted beside next fetch
              // dropped window store leaves address and data standing
              if (!(s_reg.psv_en && ea[15])) begin
                s_next.dm.wr = 1'b1;
                s_next.dm.addr = ea[15:1];
                s_next.dm.wdata = opd;
              end
            end
            cdp_pkg::OP_LD: begin
              s_next.fp = s_reg.fp;
              s_next.pm.addr = s_reg.fp;
              s_next.ld_rd = f_rd;
              s_next.ld_psv = s_reg.psv_en & ea[15];
              if (s_reg.psv_en && ea[15]) begin
                s_next.pm.addr = {s_reg.page, ea[14:1], 1'b0};
              end else begin
                // dma buffer decoded as plain ram
                s_next.dm.rd = 1'b1;
                s_next.dm.addr = ea[15:1];
              end
              s_next.st = cdp_pkg::ST_LD_WAIT;
            end
            cdp_pkg::OP_DIV: begin
              if (s_reg.div_step == 5'h00) begin
                // 32/16 takes high word, 16/16 zero
                s_next.w[`CDP_QUOT_IDX] = opa;
                s_next.w[`CDP_REM_IDX] = ex_word[12] ? opb : 16'h0000;
                s_next.divisor = opd;
                s_next.div_step = 5'h01;
              end else if (s_reg.div_step <= `CDP_DIV_BITS) begin
                s_next.w[`CDP_QUOT_IDX] = {s_reg.w[`CDP_QUOT_IDX][14:0], div_ge};
                s_next.w[`CDP_REM_IDX] = div_ge ? div_diff[15:0] : div_part[15:0];
                s_next.div_step = 5'(s_reg.div_step + 5'h01);
              end
            end
            cdp_pkg::OP_REPEAT: begin
              s_next.rpt_active = 1'b1;
              s_next.rcount = ex_word[13:0];
            end
            cdp_pkg::OP_CTRL: begin
              // core_control_reg visibility bit and window page
              s_next.psv_en = ex_word[8];
              s_next.page = ex_word[7:0];
            end
            cdp_pkg::OP_GOTO: begin
              s_next.fp = {ex_word[21:0], 1'b0};
              s_next.pm.addr = {ex_word[21:0], 1'b0};
              s_next.iw_valid = 1'b0;
            end
            cdp_pkg::OP_CALL: begin
              s_next.fp = s_reg.fp;
              s_next.pm.addr = s_reg.fp;
              s_next.dm.wr = 1'b1;
              s_next.dm.addr = sp_val[15:1];
              s_next.dm.wdata = s_reg.fp[15:0];
              s_next.w[`CDP_SP_IDX] = sp_p2;
              s_next.link = {1'b0, s_reg.in_isr, 7'h00, s_reg.fp[22:16]};
              s_next.tgt = {ex_word[21:0], 1'b0};
              s_next.st = cdp_pkg::ST_PUSH_HI;
            end
            cdp_pkg::OP_RET: begin
              s_next.fp = s_reg.fp;
              s_next.pm.addr = s_reg.fp;
              s_next.dm.rd = 1'b1;
              s_next.dm.addr = sp_m2[15:1];
              s_next.w[`CDP_SP_IDX] = sp_m2;
              s_next.st = cdp_pkg::ST_POP_LO;
            end
            default: begin
              s_next.iw_valid = 1'b1;
            end
          endcase
          if (s_reg.rpt_active) begin
            s_next.rpt_started = 1'b1;
            s_next.rpt_ir = ex_word;
            if (s_reg.rcount == 14'h0000) begin
              s_next.rpt_active = 1'b0;
              s_next.rpt_started = 1'b0;
              s_next.div_step = 5'h00;
            end else begin
              s_next.rcount = 14'(s_reg.rcount - 14'h0001);
              s_next.fp = s_reg.fp;
              s_next.pm.addr = s_reg.fp;
            end
          end
        end
      end
      cdp_pkg::ST_LD_WAIT: begin
        s_next.pm.addr = s_reg.fp;
        s_next.st = cdp_pkg::ST_LD_DATA;
      end
      cdp_pkg::ST_LD_DATA: begin
        s_next.w[s_reg.ld_rd] = s_reg.ld_psv ? pm_data_i[15:0] : dm_rdata_i;
        s_next.fp = fp_inc;
        s_next.pm.addr = fp_inc;
        s_next.iw_valid = 1'b1;
        s_next.st = cdp_pkg::ST_RUN;
      end
      cdp_pkg::ST_PUSH_HI: begin
        s_next.dm.wr = 1'b1;
        s_next.dm.addr = sp_val[15:1];
        s_next.dm.wdata = s_reg.link;
        s_next.w[`CDP_SP_IDX] = sp_p2;
        s_next.fp = s_reg.tgt;
        s_next.pm.addr = s_reg.tgt;
        s_next.iw_valid = 1'b0;
        s_next.st = cdp_pkg::ST_RUN;
      end
      cdp_pkg::ST_POP_LO: begin
        s_next.dm.rd = 1'b1;
        s_next.dm.addr = sp_m2[15:1];
        s_next.w[`CDP_SP_IDX] = sp_m2;
        s_next.st = cdp_pkg::ST_POP_HI_DATA;
      end
      cdp_pkg::ST_POP_HI_DATA: begin
        s_next.link = dm_rdata_i;
        s_next.st = cdp_pkg::ST_POP_LO_DATA;
      end
      cdp_pkg::ST_POP_LO_DATA: begin
        s_next.fp = {s_reg.link[6:0], dm_rdata_i};
        s_next.pm.addr = {s_reg.link[6:0], dm_rdata_i};
        s_next.iw_valid = 1'b0;
        // resumes an interrupted repeat where it stood
        s_next.rpt_active = s_reg.link[15];
        s_next.rpt_started = 1'b0;
        s_next.in_isr = s_reg.link[14];
        s_next.st = cdp_pkg::ST_RUN;
      end
      default: begin
        s_next.st = cdp_pkg::ST_RUN;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_reg <= '0;
      s_reg.st <= cdp_pkg::ST_RUN;
      s_reg.fp <= RESET_VECTOR;
      s_reg.pm.addr <= RESET_VECTOR;
      s_reg.pm.rd <= 1'b1;
      s_reg.w[`CDP_SP_IDX] <= `CDP_SP_RST;
      s_reg.page <= `CDP_PAGE_RST;
      s_reg.psv_en <= `CDP_PSV_RST;
    end else if (clk_en_i) begin
      s_reg <= s_next;
    end
  end

  assign pm_o = s_reg.pm;
  assign dm_o = s_reg.dm;
  assign irq_ack_o = s_reg.irq_ack;

endmodule // cdp_core
`default_nettype wire

// file: src/cdp_cfg.svh
// constants for the cpu core datapath: widths, indices, vectors, opcodes
`ifndef CDP_CFG_SVH
`define CDP_CFG_SVH
// ----------------------------------------------------------------------
// widths and register indices
// ----------------------------------------------------------------------
`define CDP_INSN_W 24
`define CDP_FP_W 23
`define CDP_DW 16
`define CDP_NREG 16
`define CDP_QUOT_IDX 4'h0
`define CDP_REM_IDX 4'h1
`define CDP_SP_IDX 4'hF
`define CDP_SP_RST 16'h0800
`define CDP_FP_STEP 23'h00_0002
`define CDP_SP_STEP 16'h0002
`define CDP_RESET_VEC 23'h00_0000
`define CDP_IRQ_VEC 23'h00_0004
`define CDP_PAGE_RST 8'h00
`define CDP_PSV_RST 1'h0
// ----------------------------------------------------------------------
// arithmetic limits
// ----------------------------------------------------------------------
`define CDP_DIV_BITS 5'h10
`define CDP_SHIFT_MAX 6'h10
// ----------------------------------------------------------------------
// major opcodes (bit 23 low) and extended sub-opcodes
// ----------------------------------------------------------------------
`define CDP_OPC_NOP 3'h0
`define CDP_OPC_ALU 3'h1
`define CDP_OPC_MOVL 3'h2
`define CDP_OPC_LD 3'h3
`define CDP_OPC_ST 3'h4
`define CDP_OPC_MUL 3'h5
`define CDP_OPC_SHIFT 3'h6
`define CDP_OPC_EXT 3'h7
`define CDP_SUB_DIV 4'h0
`define CDP_SUB_REPEAT 4'h1
`define CDP_SUB_RET 4'h2
`define CDP_SUB_CTRL 4'h3
`endif

// file: src/cdp_pkg.sv
// types shared by the cpu core datapath
package cdp_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_LD_WAIT = 3'b001,
    ST_LD_DATA = 3'b010,
    ST_PUSH_HI = 3'b011,
    ST_POP_LO = 3'b100,
    ST_POP_HI_DATA = 3'b101,
    ST_POP_LO_DATA = 3'b110
  } cdp_st_t;
  typedef enum logic [3:0] {
    OP_NOP, OP_ALU, OP_MOVL, OP_LD, OP_ST, OP_MUL, OP_SHIFT, OP_DIV,
    OP_REPEAT, OP_RET, OP_CTRL, OP_GOTO, OP_CALL
  } cdp_op_t;
  typedef struct packed {
    logic rd;
    logic [22:0] addr;
  } cdp_pm_req_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [14:0] addr;
    logic [15:0] wdata;
  } cdp_dm_req_t;
  typedef struct packed {
    cdp_st_t st;
    logic [22:0] fp;
    logic [15:0][15:0] w;
    logic iw_valid;
    logic rpt_active;
    logic rpt_started;
    logic [13:0] rcount;
    logic [23:0] rpt_ir;
    logic [4:0] div_step;
    logic [15:0] divisor;
    logic [7:0] page;
    logic psv_en;
    logic in_isr;
    logic [3:0] ld_rd;
    logic ld_psv;
    logic [15:0] link;
    logic [22:0] tgt;
    cdp_pm_req_t pm;
    cdp_dm_req_t dm;
    logic irq_ack;
  } cdp_state_t;
endpackage

// file: testbench/cdp_core_chk.sv
// port assertions for the core datapath
`timescale 1ns/100ps
`default_nettype none
module cdp_core_chk #(
  parameter logic [22:0] RESET_VECTOR = 23'h00_0000,
  parameter logic [22:0] IRQ_VECTOR = 23'h00_0004
) (
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // memory buses
  input wire cdp_pkg::cdp_pm_req_t pm_o,
  input wire logic [23:0] pm_data_i,
  input wire cdp_pkg::cdp_dm_req_t dm_o,
  input wire logic [15:0] dm_rdata_i,
  // interrupt
  input wire logic irq_i,
  input wire logic irq_ack_o
);
  // ----
  // properties
  // ----
  default clocking @(posedge mclk_i); endclocking
  // frozen cycles hold everything, so they are not judged
  default disable iff (reset_i || !clk_en_i);
  sequence push_lo_s;
    dm_o.wr;
  endsequence
  sequence push_hi_s;
    dm_o.wr && dm_o.addr == $past(dm_o.addr) + 15'h0001;
  endsequence
  // return pops two stack words back to back, then the core goes quiet
  sequence pop_pair_s;
    dm_o.rd && dm_o.addr == $past(dm_o.addr) - 15'h0001 ##1 !dm_o.rd [*2];
  endsequence
  a_reset_state: assert property (disable iff (1'b0) reset_i |=>
    pm_o.addr == RESET_VECTOR && !dm_o.rd && !dm_o.wr && !irq_ack_o)
    else $error("outputs wrong after reset");
  a_fetch_even: assert property (pm_o.rd |-> !pm_o.addr[0])
    else $error("odd program address");
  a_fetch_on: assert property (!reset_i |-> pm_o.rd)
    else $error("fetch strobe dropped");
  a_rd_pulse: assert property (dm_o.rd && !$past(dm_o.rd) |=> !dm_o.rd [*2] or pop_pair_s)
    else $error("read strobe too close");
  a_rd_no_wr: assert property (dm_o.rd |-> !dm_o.wr)
    else $error("read and write together");
  a_dm_hold: assert property (!dm_o.rd && !dm_o.wr |->
    $stable(dm_o.addr) && $stable(dm_o.wdata))
    else $error("data address moved while idle");
  a_irq_push: assert property (irq_ack_o |-> push_lo_s ##1 push_hi_s)
    else $error("interrupt push pair missing");
  a_ack_cause: assert property (irq_ack_o |-> $past(irq_i) ##1 !irq_ack_o)
    else $error("ack without request or too long");
  a_irq_vector: assert property (irq_ack_o |-> ##1 pm_o.addr == IRQ_VECTOR)
    else $error("vector not fetched");
endmodule // cdp_core_chk
bind cdp_core cdp_core_chk #(.RESET_VECTOR(RESET_VECTOR), .IRQ_VECTOR(IRQ_VECTOR)) chk_u (
  .mclk_i(mclk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .pm_o(pm_o),
  .pm_data_i(pm_data_i), .dm_o(dm_o), .dm_rdata_i(dm_rdata_i), .irq_i(irq_i),
  .irq_ack_o(irq_ack_o));
`default_nettype wire

// file: testbench/cdp_mem_model.sv
// program and data memory partner of the core datapath
`timescale 1ns/100ps
`default_nettype none
module cdp_mem_model (
  // clock and enable
  input wire logic mclk_i,
  input wire logic clk_en_i,
  // program side
  input wire cdp_pkg::cdp_pm_req_t pm_i,
  output logic [23:0] pm_data_o,
  // data side
  input wire cdp_pkg::cdp_dm_req_t dm_i,
  output logic [15:0] dm_rdata_o
);
  logic [23:0] prog [int];
  logic [15:0] data [int];
  initial begin
    pm_data_o = 24'h00_0000;
    dm_rdata_o = 16'h5a5a;
  end
  // ----
  // synchronous answers
  // ----
  always @(posedge mclk_i) begin
    if (clk_en_i) begin
      if (pm_i.rd)
        pm_data_o <= prog.exists(int'(pm_i.addr[22:1])) ? prog[int'(pm_i.addr[22:1])] : 24'h00_0000;
      else
        pm_data_o <= ~pm_data_o;
      // plain ram, idle bus toggles so stale data is never trusted
      if (dm_i.rd)
        dm_rdata_o <= data.exists(int'(dm_i.addr)) ? data[int'(dm_i.addr)] : 16'h0000;
      else
        dm_rdata_o <= ~dm_rdata_o;
      if (dm_i.wr)
        data[int'(dm_i.addr)] = dm_i.wdata;
    end
  end
endmodule // cdp_mem_model
`default_nettype wire

// file: testbench/tb_cpu_core_datapath.sv
// self-checking bench for the core datapath
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_core_datapath;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic irq_i = 1'b0;
  logic irq_ack_o;
  wire logic [23:0] pm_data_i;
  wire logic [15:0] dm_rdata_i;
  cdp_pkg::cdp_pm_req_t pm_o;
  cdp_pkg::cdp_dm_req_t dm_o;
  int miscompares = 0;
  int total_checks = 0;
  int pc = 0;
  int cyc = 0;
  int last_wr = 0;
  int q_a[$];
  int q_d[$];
  int q_g[$];
  int a, b, sa, sb, pg, v, n, hi, x;
  int sh[7] = '{3, 5, -5, 16, -16, 20, 0};
  longint p;
  logic [15:0] seed = 16'h0005;
  logic [22:0] held;
  cdp_core #(.IRQ_VECTOR(23'h00_0200)) dut_u (
    .mclk_i(mclk_i), .reset_i(reset_i), .clk_en_i(clk_en_i), .pm_o(pm_o),
    .pm_data_i(pm_data_i), .dm_o(dm_o), .dm_rdata_i(dm_rdata_i), .irq_i(irq_i),
    .irq_ack_o(irq_ack_o));
  cdp_mem_model mem_u (
    .mclk_i(mclk_i), .clk_en_i(clk_en_i), .pm_i(pm_o), .pm_data_o(pm_data_i),
    .dm_i(dm_o), .dm_rdata_o(dm_rdata_i));
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) cyc <= cyc + 1;
  // ----
  // helpers
  // ----
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [23:0] w(int opc, int f, int rd, int ra, int rb);
    return {1'b0, 3'(opc), 8'(f), 4'(rd), 4'(ra), 4'(rb)};
  endfunction
  function automatic logic [23:0] mv(int rd, int imm);
    return {1'b0, 3'h2, 4'(rd), 16'(imm)};
  endfunction
  function automatic logic [23:0] ext(int sub, int f);
    return {1'b0, 3'h7, 4'(sub), 16'(f)};
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(logic [23:0] word);
    mem_u.prog[pc] = word;
    pc++;
  endtask
  task automatic ex(int ad, int d, int g);
    q_a.push_back(ad);
    q_d.push_back(d & 16'hffff);
    q_g.push_back(g);
  endtask
  task automatic st(int r, int d, int g);
    put(w(4, 0, r, 6, 7));
    ex(16'h0080, d, g);
  endtask
  task automatic wq(int k);
    for (int i = 0; i < 3000 && q_a.size() > k; i++) @(posedge mclk_i);
  endtask
  task automatic end_sim();
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // every write is held against the model queue, gap in cycles included unless queued as -1
  always @(negedge mclk_i) begin
    if (!reset_i && clk_en_i && dm_o.wr === 1'b1) begin
      if (q_a.size() == 0) begin
        chk({1'b0, dm_o.addr, dm_o.wdata}, 32'hffff_ffff);
      end else begin
        chk({1'b0, dm_o.addr, dm_o.wdata}, {1'b0, 15'(q_a[0]), 16'(q_d[0])});
        if (q_g[0] >= 0)
          chk(cyc - last_wr, q_g[0]);
        void'(q_a.pop_front());
        void'(q_d.pop_front());
        void'(q_g.pop_front());
      end
      last_wr = cyc;
    end
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    miscompares++;
    end_sim();
  end
  // ----
  // program and expectations
  // ----
  initial begin
    seed = lfsr(seed);
    a = seed;
    seed = lfsr(seed);
    b = seed | 16'h0001;
    seed = lfsr(seed);
    pg = seed[7:0] | 8'h01;
    seed = lfsr(seed);
    v = seed;
    hi = a % b;
    sa = int'($signed(16'(a)));
    sb = int'($signed(16'(b)));
    put(mv(6, 16'h0100));
    put(mv(2, a));
    put(mv(3, b));
    put(mv(8, hi));
    put(mv(12, 16'h8246));
    for (int f = 0; f < 6; f++) begin
      put(w(1, f * 16, 4, 2, 3));
      n = f == 0 ? a + b : f == 1 ? a - b : f == 2 ? a & b : f == 3 ? a | b : f == 4 ? a ^ b : a;
      st(4, n, f == 0 ? -1 : 2);
    end
    for (int m = 0; m < 4; m++) begin
      put(w(5, m * 64, 4, 2, 3));
      x = m[1] ? sa : a;
      p = longint'(x) * longint'(m[0] ? sb : b);
      st(4, int'(p), 2);
      st(5, int'(p >> 16), 1);
    end
    for (int i = 0; i < 7; i++) begin
      put(w(6, ((sh[i] & 63) << 2) | ((i % 2) << 1), 4, 2, 0));
      n = sh[i] > 16 ? 16 : sh[i];
      st(4, n > 0 ? (i % 2 ? sa >>> n : a >> n) : a << -n, 2);
    end
    for (int m = 0; m < 2; m++) begin
      st(2, a, 1);
      put(ext(1, 17));
      put(w(7, m, 3, 2, 8));
      p = m ? longint'(hi) * 65536 + a : longint'(a);
      st(0, int'(p / b), 20);
      st(1, int'(p % b), 1);
    end
    put(ext(1, 3));
    put(w(1, 0, 13, 13, 2));
    st(13, 4 * a, 6);
    st(2, a, 1);
    put(w(3, 0, 10, 6, 7));
    st(10, a, 4);
    // window reads program, window stores dropped
    mem_u.prog[(pg << 14) | 16'h0123] = {8'h5a, 16'(v)};
    put(ext(3, 16'h0100 | pg));
    put(w(3, 0, 11, 12, 7));
    st(11, v, -1);
    put(w(4, 0, 2, 12, 7));
    put(ext(3, pg));
    put(w(4, 0, 3, 12, 7));
    ex(16'h4123, b, -1);
    put(w(3, 0, 11, 12, 7));
    st(11, b, 4);
    put({2'b10, 22'(pc + 2)});
    put(w(4, 0, 2, 6, 7));
    put({2'b11, 22'h00_00c0});
    ex(16'h0400, pc * 2, -1);
    ex(16'h0401, 0, 1);
    n = pc;
    pc = 16'h00c0;
    st(2, a, -1);
    put(ext(2, 0));
    pc = n;
    st(3, b, -1);
    n = pc;
    put({2'b10, 22'(n)});
    pc = 16'h0100;
    ex(16'h0400, n * 2, -1);
    ex(16'h0401, 0, 1);
    st(3, b, -1);
    put(ext(2, 0));
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    wq(3);
    chk(q_a.size(), 3);
    @(posedge mclk_i) clk_en_i <= 1'b0;
    @(negedge mclk_i) held = pm_o.addr;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i) chk(pm_o.addr, held);
    @(posedge mclk_i) clk_en_i <= 1'b1;
    @(posedge mclk_i) irq_i <= 1'b1;
    for (int i = 0; i < 50 && irq_ack_o !== 1'b1; i++) @(negedge mclk_i);
    chk(irq_ack_o, 1'b1);
    @(posedge mclk_i) irq_i <= 1'b0;
    wq(0);
    chk(q_a.size(), 0);
    end_sim();
  end
endmodule // tb_cpu_core_datapath
`default_nettype wire
